// ---- hw/qie_pkg.sv ----
package qie_pkg;
  localparam int unsigned QIE_NUM_SRC = 5;
  // Byte offsets of the registers
  localparam logic [11:0] QIE_OFF_EN_SET = 12'h304;
  localparam logic [11:0] QIE_OFF_EN_CLR = 12'h308;
  localparam logic [11:0] QIE_OFF_STATUS = 12'h30c;
  localparam logic [11:0] QIE_OFF_PERIOD = 12'h310;
  // Enable and status bit positions
  localparam int unsigned QIE_BIT_SAMPLE = 0;
  localparam int unsigned QIE_BIT_REPORT = 1;
  localparam int unsigned QIE_BIT_OVF = 2;
  localparam int unsigned QIE_BIT_DOUBLE = 3;
  localparam int unsigned QIE_BIT_STOP = 4;
  // Reset values
  localparam logic [4:0] QIE_RST_ENABLE = 5'h00;
  localparam logic [4:0] QIE_RST_STATUS = 5'h00;
  localparam logic [15:0] QIE_RST_PERIOD = 16'h000a;
  // Bus answer latency in cycles after request is seen
  localparam int unsigned QIE_WAIT_CYCLES = 1;
endpackage

// ---- hw/qie_report_gen.sv ----
// Counts samples and raises report and double-step events
module qie_report_gen
  import qie_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic [CNT_W-1:0] report_period_i,
  input wire logic motion_nonzero_i,
  input wire logic double_nonzero_i,
  output logic report_ready_o,
  output logic double_step_ready_o
);
  logic [CNT_W-1:0] count_reg;
  logic period_done;

  // Elaboration check: the counter needs at least two bits
  if (CNT_W < 2) begin : g_bad_width
    $error("CNT_W too small");
  end

  // Zero period treated as one sample
  assign period_done = sample_i &&
    (count_reg + CNT_W'(1) >= report_period_i);

  // Sample counter restarts each report period
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (period_done) begin
      count_reg <= '0;
    end else if (sample_i) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  // Events fire only when the totals are nonzero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      report_ready_o <= 1'b0;
      double_step_ready_o <= 1'b0;
    end else begin
      report_ready_o <= period_done && motion_nonzero_i;
      double_step_ready_o <= period_done && double_nonzero_i;
    end
  end
endmodule

// ---- hw/qie_avmm_slave.sv ----
// Avalon-MM handshake: holds waitrequest until the answer is ready
module qie_avmm_slave
  import qie_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic read_i,
  input wire logic write_i,
  output logic waitrequest_o,
  output logic accept_o
);
  logic busy_reg;

  // One wait cycle, then accept; gives the read mux a full cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= read_i || write_i;
    end
  end

  assign accept_o = busy_reg;
  assign waitrequest_o = !busy_reg;
endmodule

// ---- hw/qie_top.sv ----
// Interrupt enable bank of the quadrature decoder
module qie_top
  import qie_pkg::*;
#(
  parameter int unsigned PERIOD_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sample_written_i,
  input wire logic motion_nonzero_i,
  input wire logic double_nonzero_i,
  input wire logic motion_overflow_i,
  input wire logic double_overflow_i,
  input wire logic stopped_i,
  output logic irq_o
);
  logic [4:0] enable_reg;
  logic [4:0] status_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [4:0] events;
  logic accept;
  logic wait_raw;
  logic wr_set;
  logic wr_clr;
  logic wr_stat;
  logic wr_per;
  logic rep_evt;
  logic dbl_evt;

  // Elaboration check: period must fit the 32-bit data word
  if (PERIOD_W < 2 || PERIOD_W > 32) begin : g_bad_period
    $error("PERIOD_W out of range");
  end

  // Offset match with low byte lane present
  function automatic logic hit(input logic [11:0] off);
    return avs_address_i == off && avs_byteenable_i[0];
  endfunction

  qie_avmm_slave u_bus (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .waitrequest_o(wait_raw),
    .accept_o(accept)
  );

  qie_report_gen #(
    .CNT_W(PERIOD_W)
  ) u_rep (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sample_i(sample_written_i),
    .report_period_i(period_reg),
    .motion_nonzero_i(motion_nonzero_i),
    .double_nonzero_i(double_nonzero_i),
    .report_ready_o(rep_evt),
    .double_step_ready_o(dbl_evt)
  );

  assign wr_set = accept && avs_write_i && hit(QIE_OFF_EN_SET);
  assign wr_clr = accept && avs_write_i && hit(QIE_OFF_EN_CLR);
  assign wr_stat = accept && avs_write_i && hit(QIE_OFF_STATUS);
  assign wr_per = accept && avs_write_i && hit(QIE_OFF_PERIOD);

  // Event vector in enable-bit order
  assign events[QIE_BIT_SAMPLE] = sample_written_i;
  assign events[QIE_BIT_REPORT] = rep_evt;
  assign events[QIE_BIT_OVF] = motion_overflow_i || double_overflow_i;
  assign events[QIE_BIT_DOUBLE] = dbl_evt;
  assign events[QIE_BIT_STOP] = stopped_i;

  // Shared enable state; ones act, zeros leave bits alone
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      enable_reg <= QIE_RST_ENABLE;
    end else if (wr_set) begin
      enable_reg <= enable_reg | avs_writedata_i[4:0];
    end else if (wr_clr) begin
      enable_reg <= enable_reg & ~avs_writedata_i[4:0];
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_reg <= QIE_RST_STATUS;
    end else if (wr_stat) begin
      status_reg <= (status_reg & ~avs_writedata_i[4:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  // Report period setting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      period_reg <= PERIOD_W'(QIE_RST_PERIOD);
    end else if (wr_per) begin
      period_reg <= avs_writedata_i[PERIOD_W-1:0];
    end
  end

  // Read data registered, valid at the accepting edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && wait_raw) begin
      if (hit(QIE_OFF_EN_SET) || hit(QIE_OFF_EN_CLR)) begin
        avs_readdata_o <= {27'h0, enable_reg};
      end else if (hit(QIE_OFF_STATUS)) begin
        avs_readdata_o <= {27'h0, status_reg};
      end else if (hit(QIE_OFF_PERIOD)) begin
        avs_readdata_o <= 32'(period_reg);
      end else begin
        avs_readdata_o <= 32'h0;
      end
    end
  end

  // Waitrequest from a flop: low exactly one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && wait_raw &&
        avs_waitrequest_o);
    end
  end

  // Level interrupt from enabled sticky status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & enable_reg);
    end
  end
endmodule

// ---- verification/qie_top_sva.sv ----
module qie_top_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sample_written_i,
  input wire logic motion_overflow_i,
  input wire logic double_overflow_i,
  input wire logic stopped_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow enables, updated only at accepted writes
  logic [4:0] en_reg;
  wire ack = !avs_waitrequest_o;
  wire lane = avs_byteenable_i[0];
  wire req = avs_read_i || avs_write_i;
  wire [4:0] d = avs_writedata_i[4:0];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      en_reg <= 5'h00;
    else if (avs_write_i && ack && lane && avs_address_i == 12'h304)
      en_reg <= en_reg | d;
    else if (avs_write_i && ack && lane && avs_address_i == 12'h308)
      en_reg <= en_reg & ~d;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  read_back_a:
  assert property (avs_read_i && ack && lane &&
    avs_address_i[11:4] == 8'h30 && avs_address_i[3:0] inside {4'h4, 4'h8}
    |-> avs_readdata_o[4:0] == en_reg)
    else $error("enable readback wrong");
  ack_bound_a:
  assert property (req && !ack |-> ##[1:2] ack) else $error("no answer");
  ack_single_a:
  assert property (ack |=> !ack) else $error("answer too long");
  ack_cause_a:
  assert property (ack |-> req) else $error("answer without request");
  irq_gate_a:
  assert property (irq_o |-> $past(en_reg) != 5'h00) else $error("irq unmasked");
  irq_stop_a:
  assert property (stopped_i && en_reg[4] |-> ##[1:3] irq_o)
    else $error("stop irq missing");
  irq_ovf_a:
  assert property ((motion_overflow_i || double_overflow_i) && en_reg[2]
    |-> ##[1:3] irq_o) else $error("overflow irq missing");
  irq_sample_a:
  assert property (sample_written_i && en_reg[0] |-> ##[1:3] irq_o)
    else $error("sample irq missing");
endmodule
bind qie_top qie_top_sva u_qie_top_sva (.*);

// ---- verification/qie_top_tb_top.sv ----
module qie_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [11:0] avs_address_i = 12'h000;
  logic [31:0] avs_writedata_i = 32'h0, rdat, avs_readdata_o;
  logic [3:0] avs_byteenable_i = 4'hf, ev = 4'h0;
  logic avs_read_i = 1'h0, avs_write_i = 1'h0, avs_waitrequest_o, irq_o;
  logic motion_nonzero_i = 1'h0, double_nonzero_i = 1'h0;
  logic [4:0] enb [4] = '{5'h01, 5'h04, 5'h04, 5'h10};
  int fail_count = 0, compares = 0;
  // Event pulses come from one vector so a loop can walk them
  wire sample_written_i = ev[0];
  wire motion_overflow_i = ev[1];
  wire double_overflow_i = ev[2];
  wire stopped_i = ev[3];
  qie_top u_qie_top (.*);
  always #2 sys_clk_i = ~sys_clk_i;
  // Request held until waitrequest is sampled low
  task automatic acc(logic w, logic [11:0] a, logic [31:0] d = 32'h0);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'h0)
      @(posedge sys_clk_i);
    rdat = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    // Idle edge, so a next call never re-raises in this time step
    @(posedge sys_clk_i);
  endtask
  task automatic pulse(int k);
    ev <= 4'h1 << k;
    @(posedge sys_clk_i);
    ev <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t register value", $time);
    end
  endtask
  task automatic chk_irq(logic got, logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t irq level", $time);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well past the few hundred cycles of the run
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    acc(1'h1, 12'h3fc, 32'h1f);
    acc(1'h0, 12'h304);
    chk(rdat, 32'h0);
    acc(1'h0, 12'h3fc);
    chk(rdat, 32'h0);
    $display("reset test done");
    // Walk the enables up, then down, checking through the other address
    for (int i = 0; i < 5; i++) begin
      acc(1'h1, 12'h304, 32'h1 << i);
      acc(1'h0, 12'h308);
      chk(rdat, (32'h2 << i) - 32'h1);
    end
    acc(1'h1, 12'h308, 32'h0);
    acc(1'h0, 12'h304);
    chk(rdat, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      acc(1'h1, 12'h308, 32'h1 << i);
      acc(1'h0, 12'h304);
      chk(rdat, (32'h3e << i) & 32'h1f);
    end
    $display("enable test done");
    // Masked event is kept quiet but remembered until enabled
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      chk_irq(irq_o, 1'h0);
      acc(1'h1, 12'h304, {27'h0, enb[i]});
      repeat (2) @(posedge sys_clk_i);
      chk_irq(irq_o, 1'h1);
      acc(1'h1, 12'h30c, 32'h1f);
      pulse(i);
      chk_irq(irq_o, 1'h1);
      acc(1'h1, 12'h308, 32'h1f);
      acc(1'h1, 12'h30c, 32'h1f);
      repeat (2) @(posedge sys_clk_i);
      chk_irq(irq_o, 1'h0);
    end
    $display("irq test done");
    // Mid-run reset: enables back to zero, sample count restarts
    rst_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    acc(1'h0, 12'h304);
    chk(rdat, 32'h0);
    acc(1'h1, 12'h310, 32'h3);
    acc(1'h1, 12'h304, 32'ha);
    motion_nonzero_i <= 1'h1;
    pulse(0);
    pulse(0);
    acc(1'h0, 12'h30c);
    chk(rdat, 32'h1);
    chk_irq(irq_o, 1'h0);
    pulse(0);
    acc(1'h0, 12'h30c);
    chk(rdat, 32'h3);
    chk_irq(irq_o, 1'h1);
    // Only the double total is nonzero for the next period
    acc(1'h1, 12'h30c, 32'h1f);
    motion_nonzero_i <= 1'h0;
    double_nonzero_i <= 1'h1;
    repeat (3) pulse(0);
    acc(1'h0, 12'h30c);
    chk(rdat, 32'h9);
    chk_irq(irq_o, 1'h1);
    $display("report test done");
    tally_and_finish();
  end
endmodule
